// *** rtl/bmc_pkg.sv ***
package bmc_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam logic [ADDR_W-1:0] BASIC_MODE_CONTROL_OFS = 5'h00;

   // Field positions
   localparam int SOFT_RESET_BIT = 15;
   localparam int LOOPBACK_BIT = 14;
   localparam int SPEED_BIT = 13;
   localparam int AN_ENABLE_BIT = 12;
   localparam int POWER_DOWN_BIT = 11;
   localparam int ISOLATE_BIT = 10;
   localparam int AN_RESTART_BIT = 9;
   localparam int DUPLEX_BIT = 8;
   localparam int COL_TEST_BIT = 7;

   // Values after reset
   localparam logic RST_LOOPBACK = 1'b0;
   localparam logic RST_SPEED = 1'b1;
   localparam logic RST_POWER_DOWN = 1'b0;
   localparam logic RST_ISOLATE = 1'b0;
   localparam logic RST_AN_RESTART = 1'b0;
   localparam logic RST_DUPLEX = 1'b0;
   localparam logic RST_COL_TEST = 1'b0;
   localparam logic RST_AN_ENABLE = 1'b0;
   localparam logic [DATA_W-1:0] RSVD_READ = 16'h0000;

   // Collision test timing
   localparam int CLK_PERIOD_PS = 5000;
   localparam int BIT_TIME_100M_PS = 10000;
   localparam int COL_ASSERT_MAX_BITS = 512;
   localparam int COL_DEASSERT_MAX_BITS = 4;
   localparam int COL_ASSERT_MAX_CYC = (COL_ASSERT_MAX_BITS * BIT_TIME_100M_PS) / CLK_PERIOD_PS;
   localparam int COL_DEASSERT_MAX_CYC = (COL_DEASSERT_MAX_BITS * BIT_TIME_100M_PS) / CLK_PERIOD_PS;
   localparam int COL_LAT_CYC = 1;
endpackage

// *** rtl/col_path_if.sv ***
`timescale 1ns/1ps
interface col_path_if;
   logic tx_en;
   logic col_core;
   logic col_test;
   logic active;
   logic col;
   modport ctrl (output tx_en, output col_core, output col_test, output active, input col);
   modport path (input tx_en, input col_core, input col_test, input active, output col);
endinterface

// *** rtl/col_path.sv ***
`timescale 1ns/1ps
module col_path #(
   parameter int LAT = bmc_pkg::COL_LAT_CYC
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ce,
   col_path_if.path cp
);
   import bmc_pkg::*;

   initial begin
      if (LAT < 1 || LAT > COL_DEASSERT_MAX_CYC) begin
         $error("col_path: LAT out of range");
      end
   end

   logic [LAT-1:0] pipe_reg;
   logic [LAT-1:0] pipe_next;
   logic src;

   // Same latency both ways keeps either edge inside the tighter bound
   always_comb begin
      src = cp.active & (cp.col_test ? cp.tx_en : cp.col_core);
      pipe_next = pipe_reg;
      if (ce) begin
         // Top bit of the concatenation is the one shifted out
         pipe_next = LAT'({pipe_reg, src});
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pipe_reg <= '0;
      end else begin
         pipe_reg <= pipe_next;
      end
   end

   assign cp.col = pipe_reg[LAT-1];
endmodule

// *** rtl/phy_basic_control.sv ***
// How it works
// - Power-down stops all transceiver functions; the register stays accessible.
// - Isolate detaches the MII outputs; management keeps working.
// - Writing 1 to restart bit restarts negotiation from the beginning.
// - Restart write ignored while negotiation enable is 0.
// - Restart bit reads 1 until negotiation initiated, then clears itself.
// - Writing 0 to a pending restart bit does not disturb negotiation.
// - With negotiation disabled, duplex bit 1 selects full, 0 half duplex.
// - Collision test asserts COL within 512 bit times of TX_EN rising.
// - Collision test drops COL within 4 bit times of TX_EN falling.
// - Bits 6 to 0 ignore writes and read as zero.
// - Negotiation enabled ignores manual duplex and speed; disabled, they apply.
`timescale 1ns/1ps
module phy_basic_control (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [bmc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [bmc_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [bmc_pkg::DATA_W-1:0] reg_rdata,
   input wire logic an_enable_strap,
   output logic an_restart,
   input wire logic an_initiated,
   input wire logic an_duplex_full,
   input wire logic an_speed_100,
   output logic duplex_full,
   output logic speed_100,
   output logic core_enable,
   output logic loopback,
   input wire logic tx_en,
   input wire logic col_core,
   input wire logic crs_core,
   input wire logic rx_dv_core,
   input wire logic rx_er_core,
   input wire logic [3:0] rxd_core,
   output logic col,
   output logic col_oe,
   output logic crs,
   output logic crs_oe,
   output logic rx_dv,
   output logic rx_er,
   output logic [3:0] rxd,
   output logic rx_oe,
   output logic tx_accept
);
   import bmc_pkg::*;

   // ***************************
   // Control register
   // ***************************
   logic loopback_reg, loopback_next;
   logic speed_reg, speed_next;
   logic an_enable_reg, an_enable_next;
   logic power_down_reg, power_down_next;
   logic isolate_reg, isolate_next;
   logic an_restart_reg, an_restart_next;
   logic duplex_reg, duplex_next;
   logic col_test_reg, col_test_next;
   logic strap_taken_reg, strap_taken_next;
   logic [DATA_W-1:0] rdata_reg, rdata_next;
   logic wr_hit;
   logic [DATA_W-1:0] ctrl_view;

   function automatic logic [DATA_W-1:0] pack_ctrl(
      input logic lb, input logic spd, input logic ane, input logic pd,
      input logic iso, input logic rst_an, input logic dup, input logic ct);
      logic [DATA_W-1:0] v;
      v = RSVD_READ;
      v[LOOPBACK_BIT] = lb;
      v[SPEED_BIT] = spd;
      v[AN_ENABLE_BIT] = ane;
      v[POWER_DOWN_BIT] = pd;
      v[ISOLATE_BIT] = iso;
      v[AN_RESTART_BIT] = rst_an;
      v[DUPLEX_BIT] = dup;
      v[COL_TEST_BIT] = ct;
      return v;
   endfunction

   assign wr_hit = reg_wr && (reg_addr == BASIC_MODE_CONTROL_OFS);
   assign ctrl_view = pack_ctrl(loopback_reg, speed_reg, an_enable_reg, power_down_reg,
                                isolate_reg, an_restart_reg, duplex_reg, col_test_reg);

   always_comb begin
      loopback_next = loopback_reg;
      speed_next = speed_reg;
      an_enable_next = an_enable_reg;
      power_down_next = power_down_reg;
      isolate_next = isolate_reg;
      an_restart_next = an_restart_reg;
      duplex_next = duplex_reg;
      col_test_next = col_test_reg;
      strap_taken_next = strap_taken_reg;
      rdata_next = '0;
      if (ce) begin
         // Strap sampled once after reset release, never under the reset itself
         if (!strap_taken_reg) begin
            strap_taken_next = 1'b1;
            an_enable_next = an_enable_strap;
         end
         // Engine acknowledge clears the request; a fresh write below wins
         if (an_initiated) begin
            an_restart_next = 1'b0;
         end
         if (wr_hit) begin
            if (reg_wdata[SOFT_RESET_BIT]) begin
               // Self-clearing reset: defaults and strap reloaded in one cycle
               loopback_next = RST_LOOPBACK;
               speed_next = RST_SPEED;
               an_enable_next = an_enable_strap;
               power_down_next = RST_POWER_DOWN;
               isolate_next = RST_ISOLATE;
               an_restart_next = RST_AN_RESTART;
               duplex_next = RST_DUPLEX;
               col_test_next = RST_COL_TEST;
               strap_taken_next = 1'b1;
            end else begin
               loopback_next = reg_wdata[LOOPBACK_BIT];
               speed_next = reg_wdata[SPEED_BIT];
               an_enable_next = reg_wdata[AN_ENABLE_BIT];
               power_down_next = reg_wdata[POWER_DOWN_BIT];
               isolate_next = reg_wdata[ISOLATE_BIT];
               duplex_next = reg_wdata[DUPLEX_BIT];
               col_test_next = reg_wdata[COL_TEST_BIT];
               // Written 0 leaves a pending request alone
               if (reg_wdata[AN_RESTART_BIT] && an_enable_reg) begin
                  an_restart_next = 1'b1;
               end
            end
         end
         if (reg_rd) begin
            if (reg_addr == BASIC_MODE_CONTROL_OFS) begin
               rdata_next = ctrl_view;
            end else begin
               rdata_next = '0;
            end
         end
      end else begin
         rdata_next = rdata_reg;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         loopback_reg <= RST_LOOPBACK;
         speed_reg <= RST_SPEED;
         an_enable_reg <= RST_AN_ENABLE;
         power_down_reg <= RST_POWER_DOWN;
         isolate_reg <= RST_ISOLATE;
         an_restart_reg <= RST_AN_RESTART;
         duplex_reg <= RST_DUPLEX;
         col_test_reg <= RST_COL_TEST;
         strap_taken_reg <= 1'b0;
         rdata_reg <= '0;
      end else begin
         loopback_reg <= loopback_next;
         speed_reg <= speed_next;
         an_enable_reg <= an_enable_next;
         power_down_reg <= power_down_next;
         isolate_reg <= isolate_next;
         an_restart_reg <= an_restart_next;
         duplex_reg <= duplex_next;
         col_test_reg <= col_test_next;
         strap_taken_reg <= strap_taken_next;
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;

   // ***************************
   // Mode resolution
   // ***************************
   logic active;
   logic mii_on;

   assign active = ~power_down_reg;
   assign mii_on = active & ~isolate_reg;
   assign core_enable = active;
   assign loopback = loopback_reg & active;
   // Restart held off in power-down; bit stays pending until engine runs
   assign an_restart = an_restart_reg & an_enable_reg & active;
   assign duplex_full = an_enable_reg ? an_duplex_full : duplex_reg;
   assign speed_100 = an_enable_reg ? an_speed_100 : speed_reg;

   // ***************************
   // MII output gating
   // ***************************
   logic crs_reg, crs_next;
   logic rx_dv_reg, rx_dv_next;
   logic rx_er_reg, rx_er_next;
   logic [3:0] rxd_reg, rxd_next;

   always_comb begin
      crs_next = crs_reg;
      rx_dv_next = rx_dv_reg;
      rx_er_next = rx_er_reg;
      rxd_next = rxd_reg;
      if (ce) begin
         // Quiet values while detached so nothing stale leaks out
         crs_next = crs_core & mii_on;
         rx_dv_next = rx_dv_core & mii_on;
         rx_er_next = rx_er_core & mii_on;
         rxd_next = mii_on ? rxd_core : 4'h0;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         crs_reg <= 1'b0;
         rx_dv_reg <= 1'b0;
         rx_er_reg <= 1'b0;
         rxd_reg <= 4'h0;
      end else begin
         crs_reg <= crs_next;
         rx_dv_reg <= rx_dv_next;
         rx_er_reg <= rx_er_next;
         rxd_reg <= rxd_next;
      end
   end

   assign crs = crs_reg;
   assign rx_dv = rx_dv_reg;
   assign rx_er = rx_er_reg;
   assign rxd = rxd_reg;
   assign rx_oe = mii_on;
   assign crs_oe = mii_on;
   assign col_oe = mii_on;
   assign tx_accept = mii_on;

   // ***************************
   // Collision path
   // ***************************
   col_path_if cpi ();

   assign cpi.tx_en = tx_en & mii_on;
   assign cpi.col_core = col_core;
   assign cpi.col_test = col_test_reg;
   assign cpi.active = mii_on;

   col_path #(
      .LAT(COL_LAT_CYC)
   ) u_col_path (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .ce(ce),
      .cp(cpi.path)
   );

   assign col = cpi.col;
endmodule

// *** dv/phy_basic_control_assertions.sv ***
`timescale 1ns/1ps
module phy_basic_control_assertions (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [bmc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [bmc_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [bmc_pkg::DATA_W-1:0] reg_rdata,
   input wire logic an_restart,
   input wire logic an_initiated,
   input wire logic core_enable,
   input wire logic loopback,
   input wire logic col,
   input wire logic col_oe,
   input wire logic crs,
   input wire logic rx_oe,
   input wire logic tx_accept
);
   import bmc_pkg::*;
   // ****
   // Checks
   // ****
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // Soft reset excluded: it reloads everything
   sequence wr_ctl;
      ce && reg_wr && reg_addr == BASIC_MODE_CONTROL_OFS && !reg_wdata[SOFT_RESET_BIT];
   endsequence
   a_rsvd_zero: assert property (reg_rdata[6:0] == 7'h00)
      else $error("reserved read bits set");
   a_rdata_slot: assert property (ce && !reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data outside its slot");
   a_write_apply: assert property (wr_ctl |=> core_enable == !$past(reg_wdata[POWER_DOWN_BIT]))
      else $error("power bit not applied after write");
   a_pd_off: assert property (!core_enable |-> !rx_oe && !an_restart && !loopback)
      else $error("functions alive in power down");
   a_oe_same: assert property (col_oe == rx_oe && tx_accept == rx_oe)
      else $error("output enables disagree");
   a_iso_quiet: assert property ((ce && !rx_oe) [*2] |-> !crs && !col)
      else $error("output active while detached");
   a_restart_hold: assert property (an_restart && ce && !reg_wr && !an_initiated |=> an_restart)
      else $error("restart dropped early");
   a_restart_clear: assert property (an_initiated && ce && !reg_wr |=> !an_restart)
      else $error("restart not cleared");
endmodule
bind phy_basic_control phy_basic_control_assertions i_phy_basic_control_assertions (.clk_sys(clk_sys),
   .resetn(resetn), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .an_restart(an_restart), .an_initiated(an_initiated), .core_enable(core_enable),
   .loopback(loopback), .col(col), .col_oe(col_oe), .crs(crs), .rx_oe(rx_oe), .tx_accept(tx_accept));

// *** dv/an_engine_model.sv ***
`timescale 1ns/1ps
module an_engine_model (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic an_restart,
   input wire logic [7:0] delay,
   output logic an_initiated
);
   logic [7:0] cnt_reg;
   // Slow start keeps the pending bit readable
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cnt_reg <= 8'h00;
         an_initiated <= 1'b0;
      end else begin
         an_initiated <= an_restart && cnt_reg == delay && !an_initiated;
         cnt_reg <= (an_restart && cnt_reg != delay) ? cnt_reg + 8'h01 : 8'h00;
      end
   end
endmodule

// *** dv/tb_phy_basic_control.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; $display("BAD %0t %h %h", $time, g, e); end end
module tb_phy_basic_control;
   import bmc_pkg::*;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic ce = 1'b1;
   logic [ADDR_W-1:0] reg_addr = 5'h00;
   logic [DATA_W-1:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic tx_en = 1'b0;
   logic col_core = 1'b1;
   logic crs_core = 1'b1;
   logic an_enable_strap = 1'b0;
   logic [3:0] rxd_core = 4'hA;
   logic rx_dv;
   logic [3:0] rxd;
   logic [DATA_W-1:0] reg_rdata;
   logic an_restart, an_initiated, duplex_full, speed_100, core_enable, col, col_oe, crs, rx_oe;
   int bad_count = 0;
   int cmp_count = 0;
   int n;
   always #2.5 clk_sys = ~clk_sys;
   phy_basic_control i_phy_basic_control (.clk_sys(clk_sys), .resetn(resetn), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .an_enable_strap(an_enable_strap),
      .an_restart(an_restart), .an_initiated(an_initiated), .an_duplex_full(1'b1), .an_speed_100(1'b1),
      .duplex_full(duplex_full), .speed_100(speed_100), .core_enable(core_enable), .loopback(), .tx_en(tx_en),
      .col_core(col_core), .crs_core(crs_core), .rx_dv_core(1'b1), .rx_er_core(1'b0), .rxd_core(rxd_core),
      .col(col), .col_oe(col_oe), .crs(crs), .crs_oe(), .rx_dv(rx_dv), .rx_er(), .rxd(rxd), .rx_oe(rx_oe),
      .tx_accept());
   an_engine_model i_an_engine_model (.clk_sys(clk_sys), .resetn(resetn), .an_restart(an_restart),
      .delay(8'h14), .an_initiated(an_initiated));
   // ****
   // Bus tasks
   // ****
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(negedge clk_sys);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      `CHK(reg_rdata, e)
   endtask
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ****
   // Scenarios
   // ****
   initial begin
      repeat (10) @(posedge clk_sys);
      resetn <= 1'b1;
      rd(5'h00, 16'h2000);
      wr(5'h00, 16'h227F);
      `CHK(an_restart, 1'b0)
      rd(5'h00, 16'h2000);
      rd(5'h01, 16'h0000);
      wr(5'h00, 16'h0100);
      `CHK(duplex_full, 1'b1)
      `CHK(speed_100, 1'b0)
      wr(5'h00, 16'h2000);
      `CHK(duplex_full, 1'b0)
      wr(5'h00, 16'h1000);
      wr(5'h00, 16'h1200);
      `CHK(an_restart, 1'b1)
      `CHK(duplex_full, 1'b1)
      `CHK(speed_100, 1'b1)
      rd(5'h00, 16'h1200);
      wr(5'h00, 16'h1000);
      rd(5'h00, 16'h1200);
      for (n = 0; n < 100 && an_initiated !== 1'b1; n++) @(negedge clk_sys);
      `CHK(an_initiated, 1'b1)
      if (n == 100) tally_and_finish();
      @(negedge clk_sys);
      `CHK(an_restart, 1'b0)
      rd(5'h00, 16'h1000);
      // Core collision held high: test mode must ignore it
      wr(5'h00, 16'h0080);
      // Pipe still holds the core collision sampled at the write edge
      @(negedge clk_sys);
      `CHK(col, 1'b0)
      `CHK(crs, 1'b1)
      `CHK(rxd, 4'hA)
      @(posedge clk_sys);
      tx_en <= 1'b1;
      rxd_core <= 4'h5;
      for (n = 0; n < COL_ASSERT_MAX_CYC && col !== 1'b1; n++) @(negedge clk_sys);
      `CHK(col, 1'b1)
      if (n == COL_ASSERT_MAX_CYC) tally_and_finish();
      @(posedge clk_sys);
      tx_en <= 1'b0;
      for (n = 0; n < COL_DEASSERT_MAX_CYC && col !== 1'b0; n++) @(negedge clk_sys);
      `CHK(col, 1'b0)
      if (n == COL_DEASSERT_MAX_CYC) tally_and_finish();
      `CHK(rxd, 4'h5)
      `CHK(rx_dv, 1'b1)
      wr(5'h00, 16'h0400);
      @(negedge clk_sys);
      `CHK(rx_oe, 1'b0)
      `CHK(crs, 1'b0)
      `CHK(rxd, 4'h0)
      `CHK(rx_dv, 1'b0)
      rd(5'h00, 16'h0400);
      wr(5'h00, 16'h0800);
      `CHK(core_enable, 1'b0)
      rd(5'h00, 16'h0800);
      wr(5'h00, 16'h0000);
      `CHK(core_enable, 1'b1)
      @(posedge clk_sys);
      an_enable_strap <= 1'b1;
      // Self-clearing reset reloads negotiation enable from the strap
      wr(5'h00, 16'h8000);
      rd(5'h00, 16'h3000);
      wr(5'h00, 16'h1200);
      `CHK(an_restart, 1'b1)
      // Mid-run reset drops the pending request, strap taken again
      @(posedge clk_sys);
      resetn <= 1'b0;
      repeat (3) @(posedge clk_sys);
      resetn <= 1'b1;
      rd(5'h00, 16'h3000);
      tally_and_finish();
   end
endmodule
